/* File: dac_front_end.sv */
// DAC serial input, zero detect, mute and attenuation front end
// Notes on behaviour
// - A word-clock period holds 48 bit clocks; samples arrive MSB first.
// - Word clock high carries left data, low carries right data.
// - Audio comes only from the external serial pins, never internally.
// - Zero flagged after about 300ms of samples with upper bits all equal.
// - Left and right zero detectors count and flag independently.
// - Mute flag on zero data, system mute high, or soft-mute bit.
// - A polarity bit selects the active level of both mute flags.
// - A new attenuation target redirects the ramp from the current level.
// - Soft mute ramps to zero on target 000, soft-mute bit or system mute.
// - Forced-mute bit holds the pulse-width output low.
// - Zero-mute enable with zero on both channels forces mute.
// - After reset, framing aligns to the first falling word-clock edge.
// - A word-clock frequency change loses sync until resynchronised.
// - Sync-ignore bit keeps playback going despite lost sync.
// - Bass boost offers medium and maximum levels via enable and level bits.
// - DAC speed follows crystal pin and master-clock select only.
//
// Chosen here: the APB interface to the registers and the register addresses.
module dac_front_end
    import dac_front_pkg::*;
#(
    parameter int ZERO_LIMIT = ZERO_CYCLES
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [ADDR_W-1:0]          paddr,
    input  wire logic [DATA_W-1:0]          pwdata,
    output logic      [DATA_W-1:0]          prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       word_clock_in,
    input  wire logic                       bit_clock_in,
    input  wire logic                       serial_audio_in,
    input  wire logic                       emphasis_in,
    input  wire logic                       system_mute_input,
    input  wire logic                       crystal_select_pin,
    output logic                            left_mute_flag,
    output logic                            right_mute_flag,
    output logic                            pwm_out,
    output logic                            emphasis_out,
    output dac_front_pkg::boost_mode_t      boost_mode,
    output logic                            dac_double_speed
);
    import dac_front_pkg::*;

    // ==================================================================
    // Input synchronisers
    logic [5:0] pins_s;
    logic       wck_s;
    logic       bck_s;
    logic       sdat_s;
    logic       emph_s;
    logic       system_mute_input_s;
    logic       xtal_s;

    in_sync3 #(.W(6)) u_sync (
        .pclk       (pclk),
        .presetn    (presetn),
        .async_in   ({crystal_select_pin, system_mute_input, emphasis_in,
                      serial_audio_in, bit_clock_in, word_clock_in}),
        .stable_out (pins_s)
    );
    assign {xtal_s, system_mute_input_s, emph_s, sdat_s, bck_s, wck_s} = pins_s;

    // ==================================================================
    // APB slave
    logic [CTRL_W-1:0] ctrl_q;
    logic [ATT_W-1:0]  target_q;
    logic [DATA_W-1:0] rdata_d;
    logic              mapped;
    logic              wr_en;
    logic [DATA_W-1:0] status_w;
    logic [SAMPLE_W-1:0] sample_l_q;
    logic [SAMPLE_W-1:0] sample_r_q;
    logic              synced_q;
    logic              lost_q;
    logic [1:0]        zero_q;
    logic [ATT_W-1:0]  level_q;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == ADDR_CTRL) || (a == ADDR_ATTEN) ||
               (a == ADDR_STATUS) || (a == ADDR_SAMPLE);
    endfunction : is_mapped

    assign mapped = is_mapped(paddr);
    assign wr_en  = psel && penable && pready && pwrite && mapped;

    always_comb begin
        status_w                      = '0;
        status_w[SB_SYNCED]           = synced_q;
        status_w[SB_LOST]             = lost_q;
        status_w[SB_ZERO_L]           = zero_q[0];
        status_w[SB_ZERO_R]           = zero_q[1];
        status_w[SB_DOUBLE]           = dac_double_speed;
        status_w[SB_LEVEL_LO +: ATT_W] = level_q;
    end

    always_comb begin
        rdata_d = '0;
        unique case (paddr)
            ADDR_CTRL:   rdata_d[CTRL_W-1:0] = ctrl_q;
            ADDR_ATTEN:  rdata_d[ATT_W-1:0]  = target_q;
            ADDR_STATUS: rdata_d             = status_w;
            ADDR_SAMPLE: rdata_d             = {sample_l_q, sample_r_q};
            default:     rdata_d             = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite) begin
                prdata <= rdata_d;
            end
        end
    end

    // Forced mute and resync move only with the qualifier set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_en && paddr == ADDR_CTRL) begin
            ctrl_q <= pwdata[CTRL_W-1:0];
            if (!pwdata[CB_QUALIFIER]) begin
                ctrl_q[CB_FORCED_MUTE] <= ctrl_q[CB_FORCED_MUTE];
                ctrl_q[CB_RESYNC]      <= ctrl_q[CB_RESYNC];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_q <= ATT_RESET;
        end else if (wr_en && paddr == ADDR_ATTEN) begin
            target_q <= pwdata[ATT_W-1:0];
        end
    end

    // ==================================================================
    // Serial receiver and framing
    logic              bck_prev_q;
    logic              bck_rise;
    logic              wck_last_q;
    logic              boundary;
    logic              lr_fall;
    logic [5:0]        period_cnt_q;
    logic [4:0]        bit_idx_q;
    logic [4:0]        bit_idx_d;
    logic [SAMPLE_W-1:0] shift_q;
    logic [SAMPLE_W-1:0] shift_d;
    logic              capture;
    logic              play_ok;
    logic [2:0]        speed_q;
    logic              speed_change;

    assign bck_rise     = bck_s && !bck_prev_q;
    assign boundary     = bck_rise && (wck_s != wck_last_q);
    assign lr_fall      = boundary && !wck_s;
    assign speed_change = speed_q != {xtal_s, ctrl_q[CB_MCLK_SEL], ctrl_q[CB_PROC_DOUBLE]};
    assign bit_idx_d    = boundary ? '0 : (bit_idx_q == IDX_MAX ? IDX_MAX : bit_idx_q + 5'h01);
    assign shift_d      = boundary ? {{(SAMPLE_W-1){1'b0}}, sdat_s} : {shift_q[SAMPLE_W-2:0], sdat_s};
    assign capture      = bck_rise && (bit_idx_d == LAST_SAMPLE_BIT);
    assign play_ok      = synced_q || ctrl_q[CB_SYNC_IGNORE];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bck_prev_q <= 1'b0;
            wck_last_q <= 1'b0;
            bit_idx_q  <= '0;
            shift_q    <= '0;
            speed_q    <= '0;
        end else begin
            bck_prev_q <= bck_s;
            speed_q    <= {xtal_s, ctrl_q[CB_MCLK_SEL], ctrl_q[CB_PROC_DOUBLE]};
            if (bck_rise) begin
                wck_last_q <= wck_s;
                bit_idx_q  <= bit_idx_d;
                shift_q    <= shift_d;
            end
        end
    end

    // Bit clocks per word period, counted from a falling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_cnt_q <= '0;
        end else if (lr_fall) begin
            period_cnt_q <= 6'h01;
        end else if (bck_rise && period_cnt_q != CNT_MAX) begin
            period_cnt_q <= period_cnt_q + 6'h01;
        end
    end

    // Alignment at first falling edge; loss on rate change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            synced_q <= 1'b0;
            lost_q   <= 1'b0;
        end else if (ctrl_q[CB_RESYNC]) begin
            synced_q <= 1'b0;
            lost_q   <= 1'b0;
        end else if (synced_q && (speed_change || (lr_fall && period_cnt_q != BITS_PER_FRAME))) begin
            synced_q <= 1'b0;
            lost_q   <= 1'b1;
        end else if (lr_fall && !synced_q && !lost_q) begin
            synced_q <= 1'b1;
        end
    end

    // Left on word clock high, right on low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_l_q   <= '0;
            sample_r_q   <= '0;
            emphasis_out <= 1'b0;
        end else if (capture && play_ok) begin
            if (wck_s) begin
                sample_l_q <= shift_d;
            end else begin
                sample_r_q   <= shift_d;
                emphasis_out <= emph_s;
            end
        end
    end

    // ==================================================================
    // Zero data detection, one per channel
    logic [1:0] new_sample;
    logic [1:0] zero_cond;
    assign new_sample = {capture && play_ok && !wck_s, capture && play_ok && wck_s};

    function automatic logic upper_flat(input logic [SAMPLE_W-1:0] s);
        return (&s[SAMPLE_W-1:ZERO_IGNORE]) || !(|s[SAMPLE_W-1:ZERO_IGNORE]);
    endfunction : upper_flat

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_zero
            logic [ZCNT_W-1:0] cnt_q;
            logic              run_q;
            assign zero_cond[ch] = upper_flat(shift_d);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_q      <= '0;
                    run_q      <= 1'b0;
                    zero_q[ch] <= 1'b0;
                end else if (new_sample[ch] && !zero_cond[ch]) begin
                    cnt_q      <= '0;
                    run_q      <= 1'b0;
                    zero_q[ch] <= 1'b0;
                end else begin
                    if (new_sample[ch]) begin
                        run_q <= 1'b1;
                    end
                    if (run_q && cnt_q < ZCNT_W'(ZERO_LIMIT)) begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                    if (run_q && cnt_q >= ZCNT_W'(ZERO_LIMIT)) begin
                        zero_q[ch] <= 1'b1;
                    end
                end
            end
            AST_ZERO_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
                new_sample[ch] && !zero_cond[ch] |=> !zero_q[ch] && cnt_q == '0)
                else $error("zero flag survived a non-zero sample");
        end
    endgenerate

    // ==================================================================
    // Mute flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_mute_flag  <= 1'b0;
            right_mute_flag <= 1'b0;
        end else begin
            left_mute_flag  <= (zero_q[0] || system_mute_input_s || ctrl_q[CB_SOFT_MUTE])
                               ~^ ctrl_q[CB_POLARITY];
            right_mute_flag <= (zero_q[1] || system_mute_input_s || ctrl_q[CB_SOFT_MUTE])
                               ~^ ctrl_q[CB_POLARITY];
        end
    end

    // ==================================================================
    // Attenuation ramp, one step per frame
    logic             soft_mute;
    logic [ATT_W-1:0] goal;
    logic             frame_tick;
    assign soft_mute  = target_q == ATT_MUTE || ctrl_q[CB_SOFT_MUTE] || system_mute_input_s;
    assign goal       = soft_mute ? ATT_MUTE : target_q;
    assign frame_tick = new_sample[1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= ATT_RESET;
        end else if (frame_tick) begin
            if (level_q < goal) begin
                level_q <= level_q + 8'h01;
            end else if (level_q > goal) begin
                level_q <= level_q - 8'h01;
            end
        end
    end

    // ==================================================================
    // Scaling and first-order pulse-width modulator
    logic              forced;
    logic              pwm_sel_q;
    logic [24:0]       prod;
    logic [SAMPLE_W-1:0] scaled;
    logic [SAMPLE_W:0] acc_q;
    logic [SAMPLE_W:0] acc_d;
    assign forced = ctrl_q[CB_FORCED_MUTE] || (ctrl_q[CB_ZERO_MUTE] && &zero_q);
    assign prod   = $signed(pwm_sel_q ? sample_l_q : sample_r_q) * $signed({1'b0, level_q});
    assign scaled = prod[SAMPLE_W+ATT_W-1:ATT_W];
    assign acc_d  = {1'b0, acc_q[SAMPLE_W-1:0]} + {1'b0, scaled ^ 16'h8000};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_sel_q <= 1'b0;
            acc_q     <= '0;
            pwm_out   <= 1'b0;
        end else begin
            pwm_sel_q <= !pwm_sel_q;
            acc_q     <= acc_d;
            pwm_out   <= !forced && acc_d[SAMPLE_W];
        end
    end

    // ==================================================================
    // Bass boost and DAC speed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boost_mode       <= BOOST_OFF;
            dac_double_speed <= 1'b0;
        end else begin
            if (!ctrl_q[CB_BOOST_EN]) begin
                boost_mode <= BOOST_OFF;
            end else if (ctrl_q[CB_BOOST_LVL]) begin
                boost_mode <= BOOST_MAX;
            end else begin
                boost_mode <= BOOST_MID;
            end
            dac_double_speed <= xtal_s && !ctrl_q[CB_MCLK_SEL];
        end
    end

    // ==================================================================
    // Checks
    AST_FRAME_48: assert property (@(posedge pclk) disable iff (!presetn)
        lr_fall && synced_q && !ctrl_q[CB_RESYNC] && period_cnt_q != BITS_PER_FRAME
        |=> lost_q && !synced_q)
        else $error("bad frame length did not drop sync");
    AST_FIRST_FALL: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(synced_q) |-> $past(lr_fall))
        else $error("alignment not on a falling word clock edge");
    AST_LEFT_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        capture && play_ok && wck_s |=> sample_l_q == $past(shift_d) && $stable(sample_r_q))
        else $error("left sample not taken while word clock high");
    AST_MUTE_SYSTEM_MUTE_INPUT: assert property (@(posedge pclk) disable iff (!presetn)
        system_mute_input_s && ctrl_q[CB_POLARITY] && $stable(ctrl_q) |=> left_mute_flag && right_mute_flag)
        else $error("mute flags not active on system mute");
    AST_FORCED_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q[CB_FORCED_MUTE] |=> !pwm_out)
        else $error("output not low under forced mute");
    AST_ZERO_MUTE: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q[CB_ZERO_MUTE] && zero_q == 2'b11 |=> !pwm_out)
        else $error("zero mute did not hold output low");
    AST_SOFT_DOWN: assert property (@(posedge pclk) disable iff (!presetn)
        frame_tick && soft_mute && level_q != ATT_MUTE |=> level_q == $past(level_q) - 8'h01)
        else $error("soft mute did not ramp down");
    AST_RAMP_UP: assert property (@(posedge pclk) disable iff (!presetn)
        frame_tick && !soft_mute && level_q < target_q |=> level_q == $past(level_q) + 8'h01)
        else $error("ramp did not step toward target");
    AST_SYNC_IGNORE: assert property (@(posedge pclk) disable iff (!presetn)
        capture && !synced_q && ctrl_q[CB_SYNC_IGNORE] && !wck_s |=> sample_r_q == $past(shift_d))
        else $error("playback stopped despite sync ignore");
    AST_SPEED: assert property (@(posedge pclk) disable iff (!presetn)
        xtal_s && !ctrl_q[CB_MCLK_SEL] |=> dac_double_speed)
        else $error("double speed not selected");
endmodule : dac_front_end

/* File: dac_front_pkg.sv */
// Shared constants for the DAC input, mute and attenuation front end
package dac_front_pkg;
    // ==================================================================
    // Register map
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_ATTEN  = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_SAMPLE = 8'h0c;
    localparam int         ADDR_W      = 8;
    localparam int         DATA_W      = 32;

    // ==================================================================
    // Control register fields
    localparam int         CTRL_W          = 11;
    localparam int         CB_SOFT_MUTE    = 0;
    localparam int         CB_FORCED_MUTE  = 1;
    localparam int         CB_QUALIFIER    = 2;
    localparam int         CB_RESYNC       = 3;
    localparam int         CB_SYNC_IGNORE  = 4;
    localparam int         CB_ZERO_MUTE    = 5;
    localparam int         CB_POLARITY     = 6;
    localparam int         CB_BOOST_EN     = 7;
    localparam int         CB_BOOST_LVL    = 8;
    localparam int         CB_MCLK_SEL     = 9;
    localparam int         CB_PROC_DOUBLE  = 10;
    localparam logic [10:0] CTRL_RESET     = 11'h040;

    // ==================================================================
    // Status register fields
    localparam int         SB_SYNCED       = 0;
    localparam int         SB_LOST         = 1;
    localparam int         SB_ZERO_L       = 2;
    localparam int         SB_ZERO_R       = 3;
    localparam int         SB_DOUBLE       = 4;
    localparam int         SB_LEVEL_LO     = 8;

    // ==================================================================
    // Audio framing and attenuation
    localparam logic [5:0] BITS_PER_FRAME  = 6'h30;
    localparam logic [5:0] CNT_MAX         = 6'h3f;
    localparam int         SAMPLE_W        = 16;
    localparam int         ZERO_IGNORE     = 4;
    localparam logic [4:0] LAST_SAMPLE_BIT = 5'h0f;
    localparam logic [4:0] IDX_MAX         = 5'h1f;
    localparam int         ATT_W           = 8;
    localparam logic [7:0] ATT_MUTE        = 8'h00;
    localparam logic [7:0] ATT_RESET       = 8'hff;

    // ==================================================================
    // Timing
    localparam int         CLK_MHZ         = 200;
    localparam int         ZERO_TIME_MS    = 300;
    localparam int         ZERO_CYCLES     = ZERO_TIME_MS * CLK_MHZ * 1000;
    localparam int         ZCNT_W          = 32;

    // ==================================================================
    // Bass boost modes
    typedef enum logic [1:0] {
        BOOST_OFF,
        BOOST_MID,
        BOOST_MAX
    } boost_mode_t;
endpackage : dac_front_pkg

/* File: in_sync3.sv */
// Three-stage input synchroniser with agreement filter
module in_sync3 #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] stable_out
);
    // ==================================================================
    // Sync chain
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ==================================================================
    // Accept a change once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stable_out[i] <= 1'b0;
                end else if (s2_q[i] == s3_q[i]) begin
                    stable_out[i] <= s3_q[i];
                end
            end
        end
    endgenerate
endmodule : in_sync3

/* File: audio_source.sv */
// Serial audio source model standing in for the signal processor
module audio_source (
    output logic             word_clock_in,
    output logic             bit_clock_in,
    output logic             serial_audio_in,
    output logic             emphasis_in,
    input  wire logic [15:0] left_word,
    input  wire logic [15:0] right_word
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Frame generator, 80 ns bit clock
    initial begin
        word_clock_in = 1'b0;
        bit_clock_in = 1'b0;
        serial_audio_in = 1'b0;
        emphasis_in = 1'b1;
        forever begin
            for (int b = 0; b < 48; b++) begin
                bit_clock_in = 1'b0;
                word_clock_in = (b < 24);
                serial_audio_in = (b % 24 < 16) ? (b < 24 ? left_word[15-b] : right_word[39-b]) : ~serial_audio_in;
                #40;
                bit_clock_in = 1'b1;
                #40;
            end
        end
    end
endmodule : audio_source

/* File: dac_input_mute_control_tb.sv */
// Testbench for the DAC front end
module dac_input_mute_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dac_front_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic pready, pslverr, e, wck, bck, sdi, emi, lmf, rmf, pwm_out, emo, dbl;
    logic sys_mute = 0, xtal = 1;
    logic [15:0] lw = 16'h1234, rw = 16'ha5c3;
    boost_mode_t boost_mode;
    int n_fail = 0, n_compared = 0, c;
    always #2.5 pclk = ~pclk;
    // ==========================================
    // Instances
    audio_source audio_source_i (.word_clock_in(wck), .bit_clock_in(bck), .serial_audio_in(sdi),
        .emphasis_in(emi), .left_word(lw), .right_word(rw));
    dac_front_end #(.ZERO_LIMIT(200)) dac_front_end_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .word_clock_in(wck), .bit_clock_in(bck),
        .serial_audio_in(sdi), .emphasis_in(emi), .system_mute_input(sys_mute),
        .crystal_select_pin(xtal), .left_mute_flag(lmf), .right_mute_flag(rmf), .pwm_out(pwm_out),
        .emphasis_out(emo), .boost_mode(boost_mode), .dac_double_speed(dbl));
    // ==========================================
    // Shared tasks
    task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", s, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : apb
    task automatic frames(input int n);
        repeat (n * 768) @(posedge pclk);
    endtask : frames
    task automatic pwm_hi();
        c = 0;
        repeat (768) begin
            @(posedge pclk);
            c += (pwm_out === 1'b1);
        end
    endtask : pwm_hi
    task automatic stop_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    // ==========================================
    // Scenarios
    task automatic t_regs();
        apb(0, ADDR_CTRL, 0);
        chk("ctrl reset", r, 32'h40);
        apb(0, ADDR_ATTEN, 0);
        chk("atten reset", r, 32'hff);
        apb(0, 8'h10, 0);
        chk("unmapped err", e, 1);
    endtask : t_regs
    task automatic t_sample();
        frames(3);
        apb(0, ADDR_STATUS, 0);
        chk("synced", r[0], 1);
        apb(0, ADDR_SAMPLE, 0);
        chk("sample", r, 32'h1234a5c3);
        chk("emphasis", emo, 1);
        pwm_hi();
        chk("pwm runs", c != 0, 1);
    endtask : t_sample
    task automatic t_flags();
        sys_mute <= 1;
        repeat (10) @(posedge pclk);
        chk("flags sys", {lmf, rmf}, 2'b11);
        apb(1, ADDR_CTRL, 32'h0);
        @(posedge pclk);
        chk("flags low", {lmf, rmf}, 2'b00);
        sys_mute <= 0;
        repeat (10) @(posedge pclk);
        chk("flags idle", {lmf, rmf}, 2'b11);
        apb(1, ADDR_CTRL, 32'h1);
        @(posedge pclk);
        chk("flags soft", {lmf, rmf}, 2'b00);
        apb(1, ADDR_CTRL, 32'h40);
    endtask : t_flags
    task automatic t_zero();
        lw <= 16'hfff7;
        frames(3);
        apb(0, ADDR_STATUS, 0);
        chk("zero lr", r[3:2], 2'b01);
        chk("flags zero", {lmf, rmf}, 2'b10);
        lw <= 16'h1234;
        frames(2);
        apb(0, ADDR_STATUS, 0);
        chk("zero clear", r[3:2], 2'b00);
        lw <= 16'h0003;
        rw <= 16'hfffa;
        apb(1, ADDR_CTRL, 32'h60);
        frames(3);
        pwm_hi();
        chk("zero mute", c, 0);
        lw <= 16'h1234;
        rw <= 16'ha5c3;
        apb(1, ADDR_CTRL, 32'h40);
        frames(2);
    endtask : t_zero
    task automatic t_mute();
        apb(1, ADDR_CTRL, 32'h42);
        apb(0, ADDR_CTRL, 0);
        chk("no qualifier", r, 32'h40);
        apb(1, ADDR_CTRL, 32'h46);
        pwm_hi();
        chk("forced mute", c, 0);
        apb(1, ADDR_CTRL, 32'h44);
        pwm_hi();
        chk("unmuted", c != 0, 1);
    endtask : t_mute
    task automatic t_boost();
        for (int i = 0; i < 4; i++) begin
            apb(1, ADDR_CTRL, 32'h44 | (i << 7));
            repeat (2) @(posedge pclk);
            chk("boost", boost_mode, i == 1 ? BOOST_MID : (i == 3 ? BOOST_MAX : BOOST_OFF));
        end
    endtask : t_boost
    task automatic t_atten();
        apb(1, ADDR_ATTEN, 32'hf8);
        frames(3);
        apb(0, ADDR_STATUS, 0);
        chk("ramp mid", (r[15:8] < 8'hff) && (r[15:8] > 8'hf8), 1);
        apb(1, ADDR_ATTEN, 32'hff);
        frames(8);
        apb(0, ADDR_STATUS, 0);
        chk("ramp back", r[15:8], 8'hff);
    endtask : t_atten
    task automatic t_speed();
        chk("double", dbl, 1);
        xtal <= 0;
        repeat (8) @(posedge pclk);
        chk("xtal low", dbl, 0);
        xtal <= 1;
        apb(1, ADDR_CTRL, 32'h244);
        repeat (8) @(posedge pclk);
        chk("mclk sel", dbl, 0);
        frames(1);
        apb(0, ADDR_STATUS, 0);
        chk("lost", r[1:0], 2'b10);
        rw <= 16'h5a3c;
        apb(1, ADDR_CTRL, 32'h254);
        frames(2);
        apb(0, ADDR_SAMPLE, 0);
        chk("sync ignore", r, 32'h12345a3c);
        rw <= 16'ha5c3;
        apb(1, ADDR_CTRL, 32'h24c);
        frames(1);
        apb(1, ADDR_CTRL, 32'h244);
        frames(2);
        apb(0, ADDR_STATUS, 0);
        chk("resynced", r[1:0], 2'b01);
    endtask : t_speed
    // ==========================================
    // Main sequence and watchdog
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_regs();
        t_sample();
        t_flags();
        t_zero();
        t_mute();
        t_boost();
        t_atten();
        t_speed();
        stop_test();
    end
    initial begin
        repeat (100000) @(posedge pclk);
        n_fail++;
        stop_test();
    end
endmodule : dac_input_mute_control_tb
